// ### core/cpsc_pkg.sv
// Package for the processing-state control block: map, fields, types
package cpsc_pkg;

  // Register byte addresses (lower 16 bits)
  localparam logic [15:0] CPSC_SYSCTL_ADDR  = 16'hFFE8;
  localparam logic [15:0] CPSC_MODEMON_ADDR = 16'hFFE9;

  // System control register fields and reset value
  localparam int          CPSC_ICM_HI_POS   = 5;
  localparam int          CPSC_ICM_LO_POS   = 4;
  localparam int          CPSC_RSTSRC_POS   = 3;
  localparam int          CPSC_ONE_POS      = 0;
  localparam logic [7:0]  CPSC_SYSCTL_RESET = 8'h09;

  // Address space limit: 16 Mbytes decoded
  localparam int          CPSC_ADDR_W       = 24;

  // Bus cycle lengths in states (clock periods)
  localparam logic [1:0]  CPSC_MEM_STATES   = 2'h1;
  localparam logic [1:0]  CPSC_IO_STATES    = 2'h2;

  // Exception sequence step counts
  localparam logic [3:0]  CPSC_RST_STEPS    = 4'h2;
  localparam logic [3:0]  CPSC_PUSH_M0      = 4'h2;
  localparam logic [3:0]  CPSC_PUSH_M1      = 4'h3;

  // Vector numbers
  localparam logic [7:0]  CPSC_VEC_RESET    = 8'h00;
  localparam logic [7:0]  CPSC_VEC_TRAP0    = 8'h08;

  // Processing states
  typedef enum logic [2:0] {
    CPSC_ST_RESET,
    CPSC_ST_EXC_PUSH,
    CPSC_ST_EXC_MASK,
    CPSC_ST_EXC_VEC,
    CPSC_ST_RUN,
    CPSC_ST_SLEEP,
    CPSC_ST_STANDBY
  } cpsc_state_t;

  // Exception kinds
  typedef enum logic [1:0] {
    CPSC_EX_NONE,
    CPSC_EX_RESET,
    CPSC_EX_IRQ,
    CPSC_EX_TRAP
  } cpsc_exc_t;

  // Instruction retirement report from the core
  typedef struct packed {
    logic       done;       // Instruction completes this cycle
    logic       ctl_op;     // It was and/or/xor/load to control
    logic       trap;       // It was the trap instruction
    logic [1:0] trap_num;   // Trap vector select
    logic       sleep;      // It was the sleep instruction
  } cpsc_retire_t;

  // Internal register bus request
  typedef struct packed {
    logic                    req;   // Access request
    logic                    wr;    // Write when set
    logic                    word;  // Word access when set
    logic                    io;    // Peripheral register space
    logic [CPSC_ADDR_W-1:0]  addr;  // Byte address
    logic [15:0]             wdata; // Write data
  } cpsc_bus_t;

  // Power-down control bits gathered from other registers
  typedef struct packed {
    logic software_standby_bit;
    logic low_speed_on_bit;
    logic timer_a_clock_sel_bit;
  } cpsc_pwr_t;

  // Whole state of the control block
  typedef struct packed {
    cpsc_state_t  st;         // Processing state
    cpsc_exc_t    exc;        // Exception being handled
    logic [3:0]   step;       // Sequence step counter
    logic [7:0]   vec;        // Vector number
    logic         irq_block;  // Interrupt hold-off after reset/ctl op
    logic         irq_ena;    // Interrupts allowed at all
    logic         icm_lo;     // Interrupt control mode low bit
    logic         rst_src;    // Reset source flag
    logic         wdt_seen;   // Watchdog reset in progress
    logic [1:0]   bus_cnt;    // States left in bus cycle
    logic         bus_busy;   // Bus cycle in progress
    logic         bus_ack;    // Bus cycle completes
    logic [15:0]  rdata;      // Read data
    logic         mode_pin;   // Sampled mode pin level
    logic         run;        // Program execution flag
    logic         sleeping;   // Sleep mode
    logic         standby;    // Standby mode
    logic         push_req;   // Stack push strobe
    logic         mask_upd;   // Interrupt mask update strobe
    logic         vec_fetch;  // Vector fetch strobe
  } cpsc_regs_t;

endpackage

// ### core/cpsc_ctrl.sv
// Processing-state control: reset, exceptions, power-down, bus timing
`timescale 1ns/1ps
//
// Behaviour
// - Reset low aborts work, disables interrupts
// - Reset exception starts on clocked reset release
// - Watchdog overflow resets like external reset, but keeps the interrupt mode bit
// - Priority: reset, then interrupt, then trap
// - Interrupts taken only at instruction/sequence end
// - No interrupt after control ops or reset
// - Trap taken while executing, dropped if an interrupt is taken at the same retire
// - Reset fetches start vector, interrupts stay off
// - Push, then update mask, then fetch vector
// - Stacking depends on interrupt control mode
// - Sleep when standby and low-speed bits clear
// - Standby when standby set, others clear
// - Bus cycles last one or two states
// - On-chip memory: one state, 16-bit path
// - Peripheral registers: two states, 8/16-bit
// - 16 Mbyte decode, single-chip after reset
// - Mode monitor read-only, bit0 is pin
// - Interrupt mode field bits 5:4, upper read-only
// - Reset source flag: external 1, watchdog 0
// - Bits 7:6 read 0, reset value 09
// - Bits 2:1 read 0, bit 0 reads 1
module cpsc_ctrl
  import cpsc_pkg::*;
#(
  parameter int P_DATA_W = 16            // Internal data path width
) (
  input  wire logic          i_mclk,          // System clock
  input  wire logic          i_resetn,        // Reset input, active low
  input  wire logic          i_wdt_ovf,       // Watchdog overflow pulse
  input  wire logic          i_mode_select_pin, // Mode strap level
  input  wire logic          i_irq_req,       // Pending interrupt request
  input  wire logic [7:0]    i_irq_vec,       // Pending interrupt vector
  input  wire cpsc_retire_t  i_retire,        // Instruction retirement
  input  wire cpsc_pwr_t     i_pwr,           // Power-down control bits
  input  wire logic          i_wake,          // Wake event from power-down
  input  wire cpsc_bus_t     i_bus,           // Register/memory bus
  output logic [15:0]        o_rdata,         // Bus read data
  output logic               o_bus_ack,       // Bus cycle done pulse
  output logic               o_run,           // Program execution state
  output logic               o_sleep,         // Sleep mode
  output logic               o_standby,       // Standby, clock halted
  output logic               o_irq_ena,       // Interrupts accepted
  output logic               o_push,          // Push PC/control strobe
  output logic               o_mask_upd,      // Mask update strobe
  output logic               o_vec_fetch,     // Vector fetch strobe
  output logic [7:0]         o_vec,           // Vector number
  output logic [3:0]         o_step,          // Stacking step index
  output logic               o_icm,           // Interrupt control mode
  output logic               o_rst_src        // Reset source flag
);

  // Width the logic serves: 16-bit internal path only
  initial begin
    if (P_DATA_W != 16) begin
      $error("cpsc_ctrl: P_DATA_W must be 16");
    end
  end

  cpsc_regs_t r;       // Registered state
  cpsc_regs_t next_r;  // Next state

  // Stacking length per interrupt control mode
  function automatic logic [3:0] push_len(input logic mode);
    return mode ? CPSC_PUSH_M1 : CPSC_PUSH_M0;
  endfunction

  // System control register read image
  function automatic logic [7:0] sysctl_img(input cpsc_regs_t s);
    logic [7:0] v;
    v = 8'h00;
    v[CPSC_ICM_HI_POS] = 1'b0;
    v[CPSC_ICM_LO_POS] = s.icm_lo;
    v[CPSC_RSTSRC_POS] = s.rst_src;
    v[CPSC_ONE_POS]    = 1'b1;
    return v;
  endfunction

  // Next-state logic
  always_comb begin
    next_r = r;
    // Strobes last one cycle
    next_r.push_req  = 1'b0;
    next_r.mask_upd  = 1'b0;
    next_r.vec_fetch = 1'b0;
    next_r.bus_ack   = 1'b0;

    // Bus timing: memory 1 state, peripheral 2 states
    if (r.bus_busy) begin
      if (r.bus_cnt == CPSC_MEM_STATES) begin
        next_r.bus_busy = 1'b0;
        next_r.bus_ack  = 1'b1;
      end else begin
        next_r.bus_cnt = r.bus_cnt - 2'h1;
      end
    end else if (i_bus.req) begin
      // Peripheral space takes two states
      next_r.bus_busy = i_bus.io;
      next_r.bus_cnt  = CPSC_IO_STATES - 2'h1;
      next_r.bus_ack  = !i_bus.io;
      next_r.rdata    = 16'h0000;
      // Decode only 24-bit space, register lanes
      if (i_bus.addr[15:0] == CPSC_SYSCTL_ADDR &&
          &i_bus.addr[CPSC_ADDR_W-1:16]) begin
        if (i_bus.wr) begin
          next_r.icm_lo = i_bus.wdata[CPSC_ICM_LO_POS];
        end else begin
          next_r.rdata = {8'h00, sysctl_img(r)};
        end
      end else if (i_bus.addr[15:0] == CPSC_MODEMON_ADDR &&
                   &i_bus.addr[CPSC_ADDR_W-1:16] && !i_bus.wr) begin
        // Pin latched at the read, writes ignored
        next_r.rdata = {15'h0000, i_mode_select_pin};
        next_r.mode_pin = i_mode_select_pin;
      end
    end

    // Watchdog overflow forces the reset state
    if (i_wdt_ovf) begin
      next_r.st        = CPSC_ST_RESET;
      next_r.rst_src   = 1'b0;
      next_r.wdt_seen  = 1'b1;
      next_r.irq_ena   = 1'b0;
      next_r.run       = 1'b0;
      next_r.sleeping  = 1'b0;
      next_r.standby   = 1'b0;
      next_r.step      = 4'h0;
    end else begin
      unique case (r.st)
        // Leave reset one clock after release
        CPSC_ST_RESET: begin
          next_r.exc      = CPSC_EX_RESET;
          next_r.st       = CPSC_ST_EXC_VEC;
          next_r.vec      = CPSC_VEC_RESET;
          next_r.step     = 4'h0;
          next_r.wdt_seen = 1'b0;
          next_r.irq_ena  = 1'b0;
        end
        // Push program counter and control registers
        CPSC_ST_EXC_PUSH: begin
          next_r.push_req = 1'b1;
          next_r.step     = r.step + 4'h1;
          if (r.step + 4'h1 == push_len(r.icm_lo)) begin
            next_r.st = CPSC_ST_EXC_MASK;
          end
        end
        // Update interrupt masks after the push
        CPSC_ST_EXC_MASK: begin
          next_r.mask_upd = 1'b1;
          next_r.st       = CPSC_ST_EXC_VEC;
          next_r.step     = 4'h0;
        end
        // Fetch the vector then branch
        CPSC_ST_EXC_VEC: begin
          next_r.vec_fetch = (r.step == 4'h0);
          next_r.step      = r.step + 4'h1;
          if (r.exc == CPSC_EX_RESET) begin
            if (r.step + 4'h1 == CPSC_RST_STEPS) begin
              next_r.st        = CPSC_ST_RUN;
              next_r.run       = 1'b1;
              next_r.irq_block = 1'b1;
              next_r.exc       = CPSC_EX_NONE;
            end
          end else if (r.step == 4'h0) begin
            // End of interrupt/trap sequence: may chain
            if (i_irq_req && r.irq_ena) begin
              next_r.exc  = CPSC_EX_IRQ;
              next_r.vec  = i_irq_vec;
              next_r.st   = CPSC_ST_EXC_PUSH;
              next_r.step = 4'h0;
            end else begin
              next_r.st  = CPSC_ST_RUN;
              next_r.run = 1'b1;
              next_r.exc = CPSC_EX_NONE;
            end
          end
        end
        // Program execution
        CPSC_ST_RUN: begin
          if (i_retire.done) begin
            // Enable interrupts once first instruction retires
            next_r.irq_block = i_retire.ctl_op;
            next_r.irq_ena   = 1'b1;
            if (i_irq_req && r.irq_ena && !r.irq_block &&
                !i_retire.ctl_op) begin
              next_r.exc  = CPSC_EX_IRQ;
              next_r.vec  = i_irq_vec;
              next_r.st   = CPSC_ST_EXC_PUSH;
              next_r.step = 4'h0;
              next_r.run  = 1'b0;
            end else if (i_retire.trap) begin
              next_r.exc  = CPSC_EX_TRAP;
              next_r.vec  = CPSC_VEC_TRAP0 + {6'h00, i_retire.trap_num};
              next_r.st   = CPSC_ST_EXC_PUSH;
              next_r.step = 4'h0;
              next_r.run  = 1'b0;
            end else if (i_retire.sleep &&
                         !i_pwr.low_speed_on_bit) begin
              next_r.run = 1'b0;
              if (!i_pwr.software_standby_bit) begin
                next_r.st       = CPSC_ST_SLEEP;
                next_r.sleeping = 1'b1;
              end else if (!i_pwr.timer_a_clock_sel_bit) begin
                next_r.st      = CPSC_ST_STANDBY;
                next_r.standby = 1'b1;
              end else begin
                next_r.run = 1'b1;
              end
            end
          end
        end
        // Sleep: registers kept, wake on interrupt
        CPSC_ST_SLEEP: begin
          if (i_wake) begin
            next_r.st       = CPSC_ST_RUN;
            next_r.run      = 1'b1;
            next_r.sleeping = 1'b0;
          end
        end
        // Standby: clock halted, state kept
        CPSC_ST_STANDBY: begin
          if (i_wake) begin
            next_r.st      = CPSC_ST_RUN;
            next_r.run     = 1'b1;
            next_r.standby = 1'b0;
          end
        end
        default: begin
          next_r.st = CPSC_ST_RESET;
        end
      endcase
    end
  end

  // State register; external reset dominates everything
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      r         <= '0;
      r.st      <= CPSC_ST_RESET;
      r.rst_src <= CPSC_SYSCTL_RESET[CPSC_RSTSRC_POS];
      r.icm_lo  <= CPSC_SYSCTL_RESET[CPSC_ICM_LO_POS];
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign o_rdata     = r.rdata;
  assign o_bus_ack   = r.bus_ack;
  assign o_run       = r.run;
  assign o_sleep     = r.sleeping;
  assign o_standby   = r.standby;
  assign o_irq_ena   = r.irq_ena;
  assign o_push      = r.push_req;
  assign o_mask_upd  = r.mask_upd;
  assign o_vec_fetch = r.vec_fetch;
  assign o_vec       = r.vec;
  assign o_step      = r.step;
  assign o_icm       = r.icm_lo;
  assign o_rst_src   = r.rst_src;

endmodule

// ### test/cpsc_ctrl_props.sv
// Concurrent checks on the ports of the processing-state control block
`timescale 1ns/1ps
module cpsc_ctrl_props
  import cpsc_pkg::*;
(
  input wire logic         i_mclk,            // Clock
  input wire logic         i_resetn,          // Reset, active low
  input wire logic         i_wdt_ovf,         // Watchdog pulse
  input wire logic         i_mode_select_pin, // Strap
  input wire logic         i_irq_req,         // Interrupt level
  input wire logic [7:0]   i_irq_vec,         // Interrupt vector
  input wire cpsc_retire_t i_retire,          // Retire report
  input wire cpsc_pwr_t    i_pwr,             // Power bits
  input wire logic         i_wake,            // Wake level
  input wire cpsc_bus_t    i_bus,             // Bus request
  input wire logic [15:0]  o_rdata,           // Read data
  input wire logic         o_bus_ack,         // Bus done
  input wire logic         o_run,             // Executing
  input wire logic         o_sleep,           // Sleep
  input wire logic         o_standby,         // Standby
  input wire logic         o_irq_ena,         // Interrupts on
  input wire logic         o_push,            // Push strobe
  input wire logic         o_mask_upd,        // Mask strobe
  input wire logic         o_vec_fetch,       // Vector strobe
  input wire logic [7:0]   o_vec,             // Vector number
  input wire logic [3:0]   o_step,            // Step index
  input wire logic         o_icm,             // Interrupt mode
  input wire logic         o_rst_src          // Reset source
);
  // Every check samples on the clock and sleeps while reset is low
  default clocking dcb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  AST_RST_VEC: assert property ($rose(i_resetn) |->
    ##[1:3] (o_vec_fetch && o_vec == 8'h00 && !o_irq_ena))
    else $error("reset vector fetch missing");
  AST_WDT: assert property (i_wdt_ovf |->
    ##[1:3] (o_vec_fetch && o_vec == 8'h00 && !o_rst_src))
    else $error("watchdog reset sequence missing");
  AST_MEM: assert property (i_bus.req && !i_bus.io |->
    ##[1:2] o_bus_ack) else $error("memory access too slow");
  AST_IO: assert property (i_bus.req && i_bus.io |=>
    !o_bus_ack ##[1:2] o_bus_ack) else $error("register access timing");
  AST_TRAP: assert property (o_run && i_retire.done && i_retire.trap &&
    !i_irq_req |-> ##[1:2] o_push ##1 o_push) else $error("trap not taken");
  AST_ORDER: assert property (o_mask_upd |->
    ($past(o_push) && $past(o_push, 2) && $past(o_push, 3) == o_icm)
    ##1 o_vec_fetch) else $error("push, mask, vector order broken");
  AST_IRQ: assert property (o_run && i_retire.done && i_irq_req &&
    o_irq_ena && !i_retire.ctl_op |-> ##[1:2] o_push ##[2:5]
    (o_vec_fetch && o_vec == i_irq_vec)) else $error("interrupt not taken");
  AST_CTL: assert property (o_run && i_retire.done && i_retire.ctl_op &&
    !i_retire.trap && !i_retire.sleep |-> ##1 o_run ##1 o_run)
    else $error("interrupt taken after control op");
  AST_SLEEP: assert property (o_run && i_retire.done && i_retire.sleep &&
    !i_retire.trap && !i_irq_req && i_pwr == 3'h0 |-> ##[1:2] o_sleep)
    else $error("sleep not entered");
  AST_STBY: assert property (o_run && i_retire.done && i_retire.sleep &&
    !i_retire.trap && !i_irq_req && i_pwr == 3'h4 |-> ##[1:2] o_standby)
    else $error("standby not entered");
endmodule

bind cpsc_ctrl cpsc_ctrl_props cpsc_ctrl_props_i (
  .i_mclk, .i_resetn, .i_wdt_ovf, .i_mode_select_pin, .i_irq_req,
  .i_irq_vec, .i_retire, .i_pwr, .i_wake, .i_bus, .o_rdata, .o_bus_ack,
  .o_run, .o_sleep, .o_standby, .o_irq_ena, .o_push, .o_mask_upd,
  .o_vec_fetch, .o_vec, .o_step, .o_icm, .o_rst_src
);

// ### test/cpsc_strap_model.sv
// Model of the external reset source and the mode strap
`timescale 1ns/1ps
module cpsc_strap_model (
  input  wire logic i_mclk,     // System clock
  input  wire logic i_rst_req,  // Bench asks for reset
  output logic      o_resetn,   // Reset line, active low
  output logic      o_mode_pin  // Mode strap level
);
  logic rel_q;                  // Release, moved off the rising edge
  // Strap held high for the only usable mode, never changed
  assign o_mode_pin = 1'b1;
  // Assert at once, release on a falling edge to avoid a race
  always @(negedge i_mclk or posedge i_rst_req) begin
    rel_q <= ~i_rst_req;
  end
  assign o_resetn = rel_q & ~i_rst_req;
endmodule

// ### test/cpu_processing_state_control_test.sv
// Self-checking bench for the processing-state control block
`timescale 1ns/1ps
module cpu_processing_state_control_test;
  import cpsc_pkg::*;
  logic         i_mclk, rst_req, i_resetn, i_mode_select_pin; // Clock, reset
  logic         i_wdt_ovf, i_irq_req, i_wake;     // Event inputs
  logic [7:0]   i_irq_vec;                        // Interrupt vector
  cpsc_retire_t i_retire;                         // Retire report
  cpsc_pwr_t    i_pwr;                            // Power bits
  cpsc_bus_t    i_bus;                            // Bus request
  logic [15:0]  o_rdata, rd;                      // Read data
  logic         o_bus_ack, o_run, o_sleep, o_standby, o_irq_ena;
  logic         o_push, o_mask_upd, o_vec_fetch, o_icm, o_rst_src;
  logic [7:0]   o_vec, v;                         // Vector seen
  logic [3:0]   o_step;                           // Step index
  int           mismatches = 0, n_tests = 0, p, n_mem, n_io;
  cpsc_pwr_t    pw[3] = '{3'h0, 3'h4, 3'h2};      // Sleep, standby, bad
  logic [2:0]   ex[3] = '{3'h4, 3'h2, 3'h1};      // Sleep, standby, run

  cpsc_strap_model cpsc_strap_model_i (.i_mclk, .i_rst_req(rst_req),
    .o_resetn(i_resetn), .o_mode_pin(i_mode_select_pin));
  cpsc_ctrl cpsc_ctrl_i (.i_mclk, .i_resetn, .i_wdt_ovf, .i_mode_select_pin,
    .i_irq_req, .i_irq_vec, .i_retire, .i_pwr, .i_wake, .i_bus, .o_rdata,
    .o_bus_ack, .o_run, .o_sleep, .o_standby, .o_irq_ena, .o_push,
    .o_mask_upd, .o_vec_fetch, .o_vec, .o_step, .o_icm, .o_rst_src);

  // Free-running 40 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // Compare one value and report a difference
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus cycle; n counts edges after the taking edge until ack
  task automatic bus(input logic wr, input logic io, input logic [23:0] a,
                     input logic [15:0] d, output logic [15:0] r, output int n);
    @(negedge i_mclk);
    i_bus = '{1'b1, wr, 1'b0, io, a, d};
    @(negedge i_mclk);
    i_bus.req = 1'b0;
    n = 0;
    while (o_bus_ack !== 1'b1 && n < 9) begin
      @(negedge i_mclk);
      n++;
    end
    r = o_rdata;
  endtask

  // Report one retired instruction for a single cycle
  task automatic ret(input cpsc_retire_t r);
    @(negedge i_mclk);
    i_retire = r;
    @(negedge i_mclk);
    i_retire = '0;
  endtask

  // Count pushes up to the vector strobe, then wait for execution
  task automatic wait_vec(output logic [7:0] vv, output int pp);
    int k;
    pp = 0;
    k = 0;
    while (o_vec_fetch !== 1'b1 && k < 20) begin
      if (o_push === 1'b1) pp++;
      @(negedge i_mclk);
      k++;
    end
    vv = o_vec;
    while (o_run !== 1'b1 && k < 40) begin
      @(negedge i_mclk);
      k++;
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    print_verdict;
  end

  // Main sequence
  initial begin
    rst_req = 1'b1;
    {i_wdt_ovf, i_irq_req, i_wake} = 3'h0;
    i_irq_vec = 8'h40;
    i_retire = '0;
    i_pwr = '0;
    i_bus = '0;
    repeat (8) @(negedge i_mclk);
    chk("reset_outs", 16'h0001, {o_run, o_irq_ena, o_rst_src});
    rst_req = 1'b0;
    wait_vec(v, p);
    chk("start_vec", 16'h0000, {v, 7'h00, o_irq_ena});
    bus(1'b0, 1'b1, 24'hFFFFE8, 16'h0000, rd, n_io);
    chk("sysctl_rst", 16'h0009, rd[7:0]);
    bus(1'b1, 1'b1, 24'hFFFFE9, 16'h00FE, rd, p);
    bus(1'b0, 1'b1, 24'hFFFFE9, 16'h0000, rd, p);
    chk("mode_mon", 16'h0001, rd[7:0]);
    bus(1'b0, 1'b1, 24'hFFFFE0, 16'h0000, rd, p);
    chk("unmapped", 16'h0000, rd);
    bus(1'b0, 1'b0, 24'h001000, 16'h0000, rd, n_mem);
    chk("mem_states", 16'h0001, 16'(n_mem <= 1));
    chk("io_states", 16'(n_mem + 1), 16'(n_io));
    bus(1'b1, 1'b1, 24'hFFFFE8, 16'h00FF, rd, p);
    bus(1'b0, 1'b1, 24'hFFFFE8, 16'h0000, rd, p);
    chk("sysctl_wr", 16'h0119, {7'h00, o_icm, rd[7:0]});
    ret('{1'b1, 1'b0, 1'b0, 2'h0, 1'b0});
    i_irq_req = 1'b1;
    ret('{1'b1, 1'b1, 1'b0, 2'h0, 1'b0});
    i_irq_req = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk("ctl_no_irq", 16'h0001, o_run);
    ret('{1'b1, 1'b0, 1'b0, 2'h0, 1'b0});
    i_irq_req = 1'b1;
    ret('{1'b1, 1'b0, 1'b1, 2'h3, 1'b0});
    i_irq_req = 1'b0;
    wait_vec(v, p);
    chk("irq_first", 16'h0040, v);
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, 1'b1, 24'hFFFFE8, {11'h000, t[0], 4'h0}, rd, p);
      ret('{1'b1, 1'b0, 1'b1, t[1:0], 1'b0});
      wait_vec(v, p);
      chk("trap_vec", {8'h00, CPSC_VEC_TRAP0 + 8'(t)}, {8'h00, v});
      chk("pushes", {12'h000, t[0] ? CPSC_PUSH_M1 : CPSC_PUSH_M0},
          16'(p));
    end
    for (int k = 0; k < 3; k++) begin
      i_pwr = pw[k];
      ret('{1'b1, 1'b0, 1'b0, 2'h0, 1'b1});
      repeat (2) @(negedge i_mclk);
      chk("power_down", ex[k], {o_sleep, o_standby, o_run});
      i_wake = 1'b1;
      wait_vec(v, p);
      i_wake = 1'b0;
    end
    i_wdt_ovf = 1'b1;
    @(negedge i_mclk);
    i_wdt_ovf = 1'b0;
    wait_vec(v, p);
    chk("wdt_reset", 16'h0000, {v, 7'h00, o_rst_src});
    rst_req = 1'b1;
    @(negedge i_mclk);
    chk("abort_run", 16'h0001, {o_run, o_push, o_rst_src});
    rst_req = 1'b0;
    wait_vec(v, p);
    chk("ext_src", 16'h0001, o_rst_src);
    print_verdict;
  end
endmodule
